//--- design/dac_ctrl_params.svh
`ifndef DAC_CTRL_PARAMS_SVH
`define DAC_CTRL_PARAMS_SVH

// Clock and link timing
`define CLK_PERIOD_NS 50
`define SCLK_HALF_NS 200
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_PULSE_NS 100
`define WR_PULSE_CYC ((`WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UPD_PULSE_NS 100
`define UPD_PULSE_CYC ((`UPD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`define BIT_CNT_W 5

// Stream layout
`define FRAME_BITS 16
`define DATA_BITS 14
`define PAD_BITS 2

// Register map, byte addresses
`define ADR_W 8
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_UPDATE 8'h08
`define REG_STATUS 8'h0c

// Control fields
`define CTRL_W 4
`define CTRL_SERIAL 0
`define CTRL_MSB_FIRST 1
`define CTRL_ALIGN 2
`define CTRL_AUTO_UPD 3
`define CTRL_RESET 4'h0

// Status fields
`define STAT_BUSY 0
`define STAT_DROP 1
`define STAT_PEND 2

`endif

//--- design/dac_ctrl_pkg.sv
`include "dac_ctrl_params.svh"

package dac_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PWR = 4'h2,
    ST_SER = 4'h4,
    ST_UPD = 4'h8
  } ctrl_state_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_SHIFT = 3'h2,
    TX_GAP = 3'h4
  } tx_state_e;

  typedef logic [`DATA_BITS-1:0] sample_t;
  typedef logic [`FRAME_BITS-1:0] frame_t;
  typedef logic [`CNT_W-1:0] cnt_t;
endpackage

//--- design/dac_serial_tx.sv
`include "dac_ctrl_params.svh"

module dac_serial_tx
  import dac_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Word request
  input wire logic start,
  input wire frame_t word,
  output logic busy,
  output logic done,
  // Serial pins
  output logic sclk,
  output logic sync_n,
  output logic sdata
);

  tx_state_e state_reg, state_next;
  cnt_t half_reg, half_next;
  logic [`BIT_CNT_W-1:0] bit_reg, bit_next;
  frame_t shift_reg, shift_next;
  logic sclk_reg, sclk_next;
  logic sync_n_reg, sync_n_next;

  //////////////////////////////////////////////////////////////////////
  // Data moves on rising edges so it is settled at every falling edge
  always_comb begin
    state_next = state_reg;
    half_next = half_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    sclk_next = sclk_reg;
    sync_n_next = sync_n_reg;
    done = 1'b0;
    case (state_reg)
      TX_IDLE: begin
        if (start) begin
          shift_next = word;
          sync_n_next = 1'b0;
          sclk_next = 1'b1;
          half_next = '0;
          bit_next = '0;
          state_next = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (half_reg == `CNT_W'(`SCLK_HALF_CYC - 1)) begin
          half_next = '0;
          if (sclk_reg) begin
            sclk_next = 1'b0;
          end else if (bit_reg == `BIT_CNT_W'(`FRAME_BITS - 1)) begin
            // Frame ends only after the sixteenth falling edge
            sclk_next = 1'b1;
            sync_n_next = 1'b1;
            state_next = TX_GAP;
          end else begin
            sclk_next = 1'b1;
            shift_next = {shift_reg[`FRAME_BITS-2:0], 1'b0};
            bit_next = bit_reg + `BIT_CNT_W'(1);
          end
        end else begin
          half_next = half_reg + `CNT_W'(1);
        end
      end
      TX_GAP: begin
        if (half_reg == `CNT_W'(`SCLK_HALF_CYC - 1)) begin
          half_next = '0;
          done = 1'b1;
          state_next = TX_IDLE;
        end else begin
          half_next = half_reg + `CNT_W'(1);
        end
      end
      default: begin
        state_next = TX_IDLE;
        sclk_next = 1'b1;
        sync_n_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TX_IDLE;
      half_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      sclk_reg <= 1'b1;
      sync_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      half_reg <= half_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      sclk_reg <= sclk_next;
      sync_n_reg <= sync_n_next;
    end
  end

  assign busy = (state_reg != TX_IDLE);
  assign sclk = sclk_reg;
  assign sync_n = sync_n_reg;
  assign sdata = shift_reg[`FRAME_BITS-1];

  //////////////////////////////////////////////////////////////////////
  // Checks
  logic sclk_d_reg;
  logic [`BIT_CNT_W-1:0] falls_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b1;
      falls_reg <= '0;
    end else begin
      sclk_d_reg <= sclk_reg;
      if (sync_n_reg) begin
        falls_reg <= '0;
      end else if (sclk_d_reg && !sclk_reg) begin
        falls_reg <= falls_reg + `BIT_CNT_W'(1);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sdata_stable_a: assert property (
    $fell(sclk_reg) |-> $stable(sdata))
    else $error("serial data moved at a falling clock edge");
  sync_frame_a: assert property (
    $fell(sclk_reg) |-> !sync_n_reg)
    else $error("clock fell outside the frame");
  sixteen_falls_a: assert property (
    $rose(sync_n_reg) |-> falls_reg == `BIT_CNT_W'(`FRAME_BITS))
    else $error("frame did not carry sixteen falling edges");
  frame_gap_a: assert property (
    $rose(sync_n_reg) |-> sync_n_reg [*4])
    else $error("frame sync gap between words too short");
  clock_gated_a: assert property (
    sync_n_reg |-> sclk_reg)
    else $error("serial clock moved outside a frame");
  frame_done_c: cover property ($rose(sync_n_reg) ##[1:8] done);

endmodule

//--- design/dac_host_ctrl.sv
// Summary of operation
// - Separate update register gives double buffering.
// - Data stable at each falling serial clock.
// - Data changes on rising edge, no inversion.
// - Frame sync driven active low during data.
// - One gated sixteen-bit word per update.
// - LSB first: order low, alignment high.
// - MSB first end-framed: order high, alignment low.
// - Controller drives update strobe with serial timing.
`include "dac_ctrl_params.svh"

module dac_host_ctrl
  import dac_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [`ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdata,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  // Converter parallel pins
  output logic [`DATA_BITS-1:0] dac_data,
  output logic dac_cs_n,
  output logic dac_wr_n,
  output logic dac_update_strobe_n,
  output logic dac_serial_sel,
  // Converter serial pins
  output logic dac_sclk,
  output logic dac_sync_n,
  output logic dac_sdata,
  output logic dac_bit_order,
  output logic stream_alignment_select
);

  //////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_reg, rst_sync_reg, rst_n_s;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n_s = rst_sync_reg;

  //////////////////////////////////////////////////////////////////////
  // Bus decode and byte lanes
  logic [31:0] lane_mask, wmerge_ctrl, wmerge_data;
  logic req, wr_req;
  logic [`CTRL_W-1:0] ctrl_reg, ctrl_next;
  sample_t sample_reg, sample_next;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{wb_sel[b]}};
    end
  endgenerate

  assign req = wb_cyc & wb_stb & ~wb_ack;
  assign wr_req = req & wb_we;
  assign wmerge_ctrl = ({28'h0, ctrl_reg} & ~lane_mask)
                     | (wb_wdata & lane_mask);
  assign wmerge_data = ({18'h0, sample_reg} & ~lane_mask)
                     | (wb_wdata & lane_mask);

  //////////////////////////////////////////////////////////////////////
  // Frame word: two pad bits lead or trail, bit order per control
  sample_t sample_rev, sample_ord;
  frame_t frame_word;
  genvar i;
  generate
    for (i = 0; i < `DATA_BITS; i++) begin : g_rev
      assign sample_rev[i] = sample_reg[`DATA_BITS-1-i];
    end
  endgenerate
  assign sample_ord = ctrl_reg[`CTRL_MSB_FIRST] ? sample_reg : sample_rev;
  assign frame_word = ctrl_reg[`CTRL_ALIGN] ?
    {sample_ord, {`PAD_BITS{1'b0}}} :
    {{`PAD_BITS{1'b0}}, sample_ord};

  //////////////////////////////////////////////////////////////////////
  // Sequencer
  ctrl_state_e state_reg, state_next;
  cnt_t cnt_reg, cnt_next;
  logic cs_n_reg, cs_n_next;
  logic wr_n_reg, wr_n_next;
  logic upd_n_reg, upd_n_next;
  logic drop_reg, drop_next;
  logic pend_reg, pend_next;
  logic ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic tx_start, tx_busy, tx_done;
  logic hit_ctrl, hit_data, hit_upd, hit_stat, idle;

  assign hit_ctrl = wr_req && wb_adr == `REG_CTRL;
  assign hit_data = wr_req && wb_adr == `REG_DATA && |wb_sel[1:0];
  assign hit_upd = wr_req && wb_adr == `REG_UPDATE;
  assign hit_stat = wr_req && wb_adr == `REG_STATUS;
  assign idle = (state_reg == ST_IDLE);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cs_n_next = cs_n_reg;
    wr_n_next = wr_n_reg;
    upd_n_next = upd_n_reg;
    ctrl_next = ctrl_reg;
    sample_next = sample_reg;
    pend_next = pend_reg;
    drop_next = drop_reg;
    tx_start = 1'b0;
    ack_next = req;
    rdata_next = rdata_reg;
    if (hit_stat && wb_sel[0] && wb_wdata[`STAT_DROP]) begin
      drop_next = 1'b0;
    end
    // Manual updates asked for while busy wait here
    if (hit_upd && !ctrl_reg[`CTRL_AUTO_UPD] && !idle) begin
      pend_next = 1'b1;
    end
    // Settings and data are only taken while idle
    if ((hit_ctrl || hit_data) && (!idle || pend_reg)) begin
      drop_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        cnt_next = '0;
        if (pend_reg) begin
          pend_next = 1'b0;
          upd_n_next = 1'b0;
          state_next = ST_UPD;
        end else if (hit_ctrl) begin
          ctrl_next = wmerge_ctrl[`CTRL_W-1:0];
        end else if (hit_data) begin
          sample_next = wmerge_data[`DATA_BITS-1:0];
          if (ctrl_reg[`CTRL_SERIAL]) begin
            state_next = ST_SER;
          end else begin
            cs_n_next = 1'b0;
            wr_n_next = 1'b0;
            state_next = ST_PWR;
          end
        end else if (hit_upd && !ctrl_reg[`CTRL_AUTO_UPD]) begin
          upd_n_next = 1'b0;
          state_next = ST_UPD;
        end
      end
      ST_PWR: begin
        // Select stays low a cycle past the rising strobe for latch hold
        cnt_next = cnt_reg + `CNT_W'(1);
        if (cnt_reg == `CNT_W'(`WR_PULSE_CYC - 1)) begin
          wr_n_next = 1'b1;
        end else if (cnt_reg == `CNT_W'(`WR_PULSE_CYC)) begin
          cs_n_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_SER: begin
        // Start is issued one cycle late so the word sees new data
        tx_start = !tx_busy && !tx_done && cnt_reg == '0;
        if (tx_start) begin
          cnt_next = `CNT_W'(1);
        end
        if (tx_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_UPD: begin
        if (cnt_reg == `CNT_W'(`UPD_PULSE_CYC - 1)) begin
          upd_n_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg + `CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
        cs_n_next = 1'b1;
        wr_n_next = 1'b1;
        upd_n_next = 1'b1;
      end
    endcase
    // Auto mode keeps the strobe tied low, as hardwired boards do
    if (ctrl_next[`CTRL_AUTO_UPD]) begin
      upd_n_next = 1'b0;
    end else if (state_next != ST_UPD) begin
      upd_n_next = 1'b1;
    end
    if (req) begin
      case (wb_adr)
        `REG_CTRL: rdata_next = {28'h0, ctrl_reg};
        `REG_DATA: rdata_next = {18'h0, sample_reg};
        `REG_STATUS: rdata_next = {29'h0, pend_reg, drop_reg, !idle};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      cs_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      upd_n_reg <= 1'b1;
      ctrl_reg <= `CTRL_RESET;
      sample_reg <= '0;
      pend_reg <= 1'b0;
      drop_reg <= 1'b0;
      wb_ack <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cs_n_reg <= cs_n_next;
      wr_n_reg <= wr_n_next;
      upd_n_reg <= upd_n_next;
      ctrl_reg <= ctrl_next;
      sample_reg <= sample_next;
      pend_reg <= pend_next;
      drop_reg <= drop_next;
      wb_ack <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  dac_serial_tx u_tx (
    .clk(ref_clk),
    .rst_n(rst_n_s),
    .start(tx_start),
    .word(frame_word),
    .busy(tx_busy),
    .done(tx_done),
    .sclk(dac_sclk),
    .sync_n(dac_sync_n),
    .sdata(dac_sdata)
  );

  assign wb_rdata = rdata_reg;
  assign dac_data = sample_reg;
  assign dac_cs_n = cs_n_reg;
  assign dac_wr_n = wr_n_reg;
  assign dac_update_strobe_n = upd_n_reg;
  assign dac_serial_sel = ctrl_reg[`CTRL_SERIAL];
  assign dac_bit_order = ctrl_reg[`CTRL_MSB_FIRST];
  assign stream_alignment_select = ctrl_reg[`CTRL_ALIGN];

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_s);

  strobe_vs_select_a: assert property (
    !ctrl_reg[`CTRL_AUTO_UPD] && !upd_n_reg |-> cs_n_reg)
    else $error("update strobe low while select low");
  auto_strobe_a: assert property (
    ctrl_reg[`CTRL_AUTO_UPD] |-> !upd_n_reg)
    else $error("auto update strobe not held low");
  frame_no_update_a: assert property (
    !dac_sync_n && !ctrl_reg[`CTRL_AUTO_UPD] |-> upd_n_reg)
    else $error("manual update inside a serial frame");
  first_bit_a: assert property (
    $fell(dac_sync_n) && ctrl_reg[`CTRL_ALIGN] |->
      dac_sdata == (ctrl_reg[`CTRL_MSB_FIRST] ?
        sample_reg[`DATA_BITS-1] : sample_reg[0]))
    else $error("first stream bit is not the selected end");
  lead_pad_a: assert property (
    $fell(dac_sync_n) && !ctrl_reg[`CTRL_ALIGN] |-> !dac_sdata)
    else $error("leading pad bit not zero");
  wr_width_a: assert property (
    $fell(dac_wr_n) |-> !dac_wr_n [*2] ##1 dac_wr_n)
    else $error("write strobe width wrong");
  upd_pulse_a: assert property (
    $fell(upd_n_reg) && !ctrl_reg[`CTRL_AUTO_UPD] |->
      !upd_n_reg [*2] ##1 upd_n_reg)
    else $error("manual update pulse width wrong");
  ser_frame_a: assert property (
    $rose(state_reg == ST_SER) |-> ##[1:8] $fell(dac_sync_n))
    else $error("serial word did not start");
  ack_pulse_a: assert property (
    wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");

  par_write_c: cover property ($rose(dac_wr_n) && !upd_n_reg);
  man_update_c: cover property ($fell(upd_n_reg) && dac_cs_n);
  lsb_frame_c: cover property ($rose(dac_sync_n) && !dac_bit_order);
  drop_c: cover property ($rose(drop_reg));

endmodule

//--- test/dac_device_model.sv
`include "dac_ctrl_params.svh"

module dac_device_model
  import dac_ctrl_pkg::*;
(
  // Parallel pins
  input wire logic [`DATA_BITS-1:0] data,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic upd_n,
  input wire logic ser,
  // Serial pins
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdata,
  input wire logic order,
  input wire logic align,
  // Observed latch state
  output sample_t in_lat,
  output sample_t dac_out,
  output int n_upd,
  output int last_bits,
  output int n_clash
);
  timeunit 1ns;
  timeprecision 1ps;

  frame_t sr;
  int cnt;
  logic upd_rose;

  initial begin
    in_lat = '0;
    dac_out = '0;
    n_upd = 0;
    last_bits = 0;
    n_clash = 0;
    cnt = 0;
    sr = '0;
    upd_rose = 1'b0;
  end

  // First received data bit sits at the top of the chosen window
  function automatic sample_t pick_sample(frame_t f, logic msb, logic trail);
    sample_t v;
    sample_t r;
    v = trail ? f[15:2] : f[13:0];
    for (int i = 0; i < `DATA_BITS; i++) r[i] = v[`DATA_BITS-1-i];
    return msb ? v : r;
  endfunction

  task load_dac;
    dac_out = in_lat;
    n_upd++;
  endtask

  // Parallel bus is ignored while the select pin chooses serial
  always @(posedge wr_n) if (!ser && !cs_n) begin
    in_lat = data;
    if (!upd_n) load_dac();
  end

  always @(negedge upd_n) begin
    if (!cs_n && !wr_n) n_clash++;
    if (!(ser && !sync_n)) load_dac();
  end

  always @(posedge upd_n) if (ser && !sync_n) upd_rose = 1'b1;

  // Data is taken on the falling serial clock inside the frame only
  always @(negedge sclk) if (ser && !sync_n) begin
    sr = {sr[`FRAME_BITS-2:0], sdata};
    cnt++;
    if (cnt == `FRAME_BITS) begin
      in_lat = pick_sample(sr, order, align);
      if (!upd_n && !upd_rose) load_dac();
    end
  end

  always @(posedge sync_n) begin
    last_bits = cnt;
    cnt = 0;
    upd_rose = 1'b0;
  end
endmodule

//--- test/testbench.sv
`include "dac_ctrl_params.svh"

module testbench
  import dac_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [`ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdata, wb_rdata;
  logic [`DATA_BITS-1:0] dac_data;
  logic cs_n, wr_n, upd_n, ser, sclk, sync_n, sdata, order, align;
  sample_t in_lat, dac_out;
  int n_upd, last_bits, n_clash;
  int num_errors = 0;
  int total_checks = 0;

  dac_host_ctrl i_dac_host_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata),
    .wb_ack(wb_ack), .dac_data(dac_data), .dac_cs_n(cs_n),
    .dac_wr_n(wr_n), .dac_update_strobe_n(upd_n), .dac_serial_sel(ser),
    .dac_sclk(sclk), .dac_sync_n(sync_n), .dac_sdata(sdata),
    .dac_bit_order(order), .stream_alignment_select(align));

  dac_device_model i_dac_device_model (.data(dac_data), .cs_n(cs_n),
    .wr_n(wr_n), .upd_n(upd_n), .ser(ser), .sclk(sclk), .sync_n(sync_n),
    .sdata(sdata), .order(order), .align(align), .in_lat(in_lat),
    .dac_out(dac_out), .n_upd(n_upd), .last_bits(last_bits),
    .n_clash(n_clash));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  task chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task chk_s(input sample_t got, input sample_t exp, input string m);
    chk_w({18'h0, got}, {18'h0, exp}, m);
  endtask

  task chk_b(input logic got, input logic exp, input string m);
    chk_w({31'h0, got}, {31'h0, exp}, m);
  endtask

  // Reads ack before this edge's updates land, then releases at the edge
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 20) chk_b(1'b0, 1'b1, "ack timeout");
    @(posedge ref_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task wait_idle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(`REG_STATUS, s);
      n++;
    end while ((s[`STAT_BUSY] || s[`STAT_PEND]) && n < 100);
    chk_b(n < 100, 1'b1, "idle timeout");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk_b(sclk, 1'b1, "sclk idle");
    chk_b(sync_n, 1'b1, "sync idle");
    chk_b(upd_n, 1'b1, "strobe idle");
    $display("test reset done");
  endtask

  task t_par_auto;
    wr(`REG_CTRL, 32'h8);
    wr(`REG_DATA, 32'h1abc);
    wait_idle();
    chk_s(dac_out, 14'h1abc, "auto output");
    $display("test par_auto done");
  endtask

  task t_par_manual;
    int n0;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_DATA, 32'hffff_0155);
    wait_idle();
    chk_s(in_lat, 14'h0155, "input latch");
    chk_s(dac_out, 14'h1abc, "output held");
    n0 = n_upd;
    wr(`REG_UPDATE, 32'h0);
    wait_idle();
    chk_s(dac_out, 14'h0155, "manual output");
    chk_w(32'(n_upd - n0), 32'h1, "update count");
    chk_w(32'(n_clash), 32'h0, "latch overlap");
    $display("test par_manual done");
  endtask

  // Values chosen so a shifted word shows; all but 14'h3807 also show a reversed one
  task t_serial;
    sample_t vals[4] = '{14'h2c31, 14'h0e5a, 14'h3807, 14'h1249};
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(`REG_CTRL, {28'h0, 1'b1, m[1], m[0], 1'b1});
      chk_b(order, m[0], "order pin");
      chk_b(align, m[1], "align pin");
      wr(`REG_DATA, {18'h0, vals[i]});
      wait_idle();
      chk_s(dac_out, vals[i], "serial output");
      chk_w(32'(last_bits), 32'd16, "bits per frame");
      chk_b(sclk, 1'b1, "sclk after frame");
    end
    $display("test serial done");
  endtask

  task t_ser_manual;
    logic [31:0] s;
    int n0;
    wr(`REG_CTRL, 32'h3);
    n0 = n_upd;
    wr(`REG_DATA, 32'h1d2e);
    wr(`REG_UPDATE, 32'h0);
    wr(`REG_DATA, 32'h0777);
    rd(`REG_STATUS, s);
    chk_b(s[`STAT_DROP], 1'b1, "drop flag");
    chk_b(s[`STAT_PEND], 1'b1, "pending flag");
    wait_idle();
    chk_s(dac_out, 14'h1d2e, "serial manual out");
    chk_w(32'(n_upd - n0), 32'h1, "one update");
    wr(`REG_STATUS, 32'h2);
    rd(`REG_STATUS, s);
    chk_w(s, 32'h0, "status cleared");
    rd(8'h10, s);
    chk_w(s, 32'h0, "unmapped read");
    rd(`REG_CTRL, s);
    chk_w(s, 32'h3, "ctrl readback");
    $display("test ser_manual done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = '0;
    wb_sel = 4'hf;
    wb_wdata = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_par_auto();
    t_par_manual();
    t_serial();
    t_ser_manual();
    give_verdict();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #500000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule
